// ---- core/rap_pkg.sv ----
// constants, types and helpers of the radio facility preselector
// assumes one 25 MHz core clock; drum pins arrive asynchronously
package rap_pkg;

  localparam int WORD_W = 14;                 // drum and core word width
  localparam int ADDR_W = 12;                 // core address width
  localparam int NUM_FAC = 350;               // records per revolution
  localparam int FAC_W = 9;                   // record counter width
  localparam int NUM_TRACKS = 20;             // dedicated facility tracks
  localparam int TRK_W = 5;
  localparam int NUM_GRP = 5;
  localparam int LF_N = 127;
  localparam int LF_RANGE_MAX = 32;           // range stations sit in the first lf slots
  localparam int VHF_N = 127;
  localparam int MKR_N = 32;
  localparam int VHF_END = LF_N + VHF_N;
  localparam int OUTER_END = VHF_END + MKR_N;
  localparam int MIDDLE_END = OUTER_END + MKR_N;

  // record layout, one drum word each
  localparam int RECW = 8;
  localparam int REC_AW = 3;
  localparam int W_FLO = 0;                   // lower frequency limit
  localparam int W_FHI = 1;                   // upper frequency limit
  localparam int W_XLEFT = 2;                 // west bound
  localparam int W_XRIGHT = 3;                // east bound
  localparam int W_YUP = 4;                   // north bound
  localparam int W_YLOW = 5;                  // south bound
  localparam int WPT = NUM_FAC * RECW / NUM_TRACKS;  // words per track
  localparam int WPT_W = 8;

  // revolution timing
  localparam int CLK_HZ = 25000000;
  localparam int REV_PER_S = 40;
  localparam int REV_CYC = CLK_HZ / REV_PER_S;
  localparam int CNT_W = 20;

  // marker receiver is untuned; its inspected value is a fixed code
  localparam int MKR_FREQ_MC = 75;
  localparam logic [WORD_W-1:0] MKR_TUNE = WORD_W'(MKR_FREQ_MC);

  localparam logic [ADDR_W-1:0] CORE_BASE = 12'h200;  // first receiver block in core

  typedef enum logic [2:0] {GRP_LF, GRP_VHF, GRP_OUTER, GRP_MIDDLE, GRP_FAN} rap_grp_e;
  typedef enum logic {SC_IDLE, SC_RUN} rap_scan_e;
  typedef enum logic {XF_IDLE, XF_SEND} rap_xfer_e;

  // group of a record from its place in the scan
  function automatic rap_grp_e rap_grp_of(input logic [FAC_W-1:0] idx);
    if (idx < FAC_W'(LF_N)) return GRP_LF;
    if (idx < FAC_W'(VHF_END)) return GRP_VHF;
    if (idx < FAC_W'(OUTER_END)) return GRP_OUTER;
    if (idx < FAC_W'(MIDDLE_END)) return GRP_MIDDLE;
    return GRP_FAN;
  endfunction : rap_grp_of

  // fixed core word for a receiver block and word index
  function automatic logic [ADDR_W-1:0] rap_core_addr(input rap_grp_e g, input logic [REC_AW-1:0] w);
    return CORE_BASE + ADDR_W'(int'(g) * RECW) + ADDR_W'(w);
  endfunction : rap_core_addr

endpackage : rap_pkg

// ---- core/rap_window.sv ----
// inclusive bound comparator used for frequency and position tests
// assumes unsigned operands; lower bound not above upper bound
`timescale 1ns/1ns
module rap_window #(
  parameter int W = 14
) (
  input wire logic [W-1:0] value_i,  // quantity under test
  input wire logic [W-1:0] lo_i,     // lower limit
  input wire logic [W-1:0] hi_i,     // upper limit
  output logic inside_o              // value within limits
);

  // equality with a limit counts as inside
  assign inside_o = (value_i >= lo_i) && (value_i <= hi_i);

endmodule : rap_window

// ---- core/rap_preselector.sv ----
// radio facility preselector: drum scan, eligibility tests, core transfer
// assumes drum pins asynchronous to clk_i; core port same clock, mem_gnt_i from priority logic
`timescale 1ns/1ns
module rap_preselector #(
  parameter int REV_CYCLES = rap_pkg::REV_CYC  // nominal clocks per revolution
) (
  input wire logic clk_i,                                 // 25 MHz core clock
  input wire logic rstn_i,                                // async reset, active low
  input wire logic drum_clk_i,                            // drum word clock pin
  input wire logic drum_idx_i,                            // revolution index pin
  input wire logic [rap_pkg::WORD_W-1:0] drum_data_i,     // facility track read data
  input wire logic [rap_pkg::WORD_W-1:0] lf_tune_i,       // lf receiver tuning
  input wire logic [rap_pkg::WORD_W-1:0] vhf_tune_i,      // vhf/uhf receiver tuning
  input wire logic [rap_pkg::WORD_W-1:0] ac_x_i,          // aircraft east-west
  input wire logic [rap_pkg::WORD_W-1:0] ac_y_i,          // aircraft north-south
  input wire logic mem_gnt_i,                             // core write accepted
  output logic drum_rd_en_o,                              // facility heads reading
  output logic drum_wr_en_o,                              // facility write gate, held off
  output logic [rap_pkg::TRK_W-1:0] track_sel_o,          // facility track in use
  output logic mem_wr_o,                                  // core write request
  output logic [rap_pkg::ADDR_W-1:0] mem_addr_o,          // core write address
  output logic [rap_pkg::WORD_W-1:0] mem_data_o,          // core write data
  output logic [rap_pkg::NUM_GRP-1:0] sel_valid_o,        // group chosen this revolution
  output logic lf_range_o,                                // lf winner is a range station
  output logic scan_done_o,                               // pulse after last record
  output logic overrun_o,                                 // winner lost, transfer busy
  output logic idx_lost_o                                 // index missing too long
);
  import rap_pkg::*;

  localparam logic [CNT_W-1:0] WD_LIMIT = CNT_W'(REV_CYCLES + REV_CYCLES / 8);

  // pin synchronisers
  logic [2:0] clk_sync_reg, clk_sync_next;
  logic [2:0] idx_sync_reg, idx_sync_next;
  logic [WORD_W-1:0] dat_s1_reg, dat_s1_next, dat_s2_reg, dat_s2_next;
  logic word_rise, idx_rise;

  always_comb begin
    clk_sync_next = {clk_sync_reg[1:0], drum_clk_i};
    idx_sync_next = {idx_sync_reg[1:0], drum_idx_i};
    dat_s1_next = drum_data_i;
    dat_s2_next = dat_s1_reg;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_sync_reg <= 3'h0;
      idx_sync_reg <= 3'h0;
      dat_s1_reg <= '0;
      dat_s2_reg <= '0;
    end else begin
      clk_sync_reg <= clk_sync_next;
      idx_sync_reg <= idx_sync_next;
      dat_s1_reg <= dat_s1_next;
      dat_s2_reg <= dat_s2_next;
    end
  end

  // edges only look past the first stage
  assign word_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
  assign idx_rise = idx_sync_reg[1] & ~idx_sync_reg[2];

  // scan state
  rap_scan_e scan_reg, scan_next;
  logic [WORD_W-1:0] rec_mem_reg [RECW];
  logic [WORD_W-1:0] rec_mem_next [RECW];
  logic [REC_AW-1:0] word_cnt_reg, word_cnt_next;
  logic [FAC_W-1:0] rec_cnt_reg, rec_cnt_next;
  logic [WPT_W-1:0] twc_reg, twc_next;
  logic [TRK_W-1:0] track_reg, track_next;
  logic [NUM_GRP-1:0] won_reg, won_next;
  logic rec_done_reg, rec_done_next;
  logic rd_en_reg, rd_en_next;
  logic done_reg, done_next;
  logic lf_range_reg, lf_range_next;

  // eligibility of the record just completed
  rap_grp_e cur_grp;
  logic [WORD_W-1:0] tune;
  logic f_ok, x_ok, y_ok, all_pass, xfer_start, lost_evt;
  rap_xfer_e xf_reg, xf_next;

  assign cur_grp = rap_grp_of(rec_cnt_reg);

  // markers compare a fixed code against wide limits, no bypass
  always_comb begin
    unique case (cur_grp)
      GRP_LF: tune = lf_tune_i;
      GRP_VHF: tune = vhf_tune_i;
      default: tune = MKR_TUNE;
    endcase
  end

  // only frequency and the two coordinates are inspected
  rap_window #(.W(WORD_W)) u_freq (
    .value_i(tune), .lo_i(rec_mem_reg[W_FLO]), .hi_i(rec_mem_reg[W_FHI]), .inside_o(f_ok)
  );
  rap_window #(.W(WORD_W)) u_xpos (
    .value_i(ac_x_i), .lo_i(rec_mem_reg[W_XLEFT]), .hi_i(rec_mem_reg[W_XRIGHT]), .inside_o(x_ok)
  );
  rap_window #(.W(WORD_W)) u_ypos (
    .value_i(ac_y_i), .lo_i(rec_mem_reg[W_YLOW]), .hi_i(rec_mem_reg[W_YUP]), .inside_o(y_ok)
  );

  assign all_pass = f_ok & x_ok & y_ok;
  // first qualifier of a group that finds the transfer idle wins; no qualifier means no transfer
  assign xfer_start = rec_done_reg & all_pass & ~won_reg[cur_grp] & (xf_reg == XF_IDLE);
  // a winner that meets a busy transfer is dropped and flagged
  assign lost_evt = rec_done_reg & all_pass & ~won_reg[cur_grp] & (xf_reg != XF_IDLE);

  // drum scan sequencing, restarted by every index mark
  always_comb begin
    scan_next = scan_reg;
    rec_mem_next = rec_mem_reg;
    word_cnt_next = word_cnt_reg;
    rec_cnt_next = rec_cnt_reg;
    twc_next = twc_reg;
    track_next = track_reg;
    won_next = won_reg;
    rec_done_next = 1'b0;
    done_next = 1'b0;
    lf_range_next = lf_range_reg;
    if (idx_rise) begin
      scan_next = SC_RUN;
      word_cnt_next = '0;
      rec_cnt_next = '0;
      twc_next = '0;
      track_next = '0;
      won_next = '0;
    end else begin
      unique case (scan_reg)
        SC_IDLE: ;
        SC_RUN: begin
          if (word_rise) begin
            rec_mem_next[word_cnt_reg] = dat_s2_reg;
            // walk the facility tracks in turn
            if (twc_reg == WPT_W'(WPT - 1)) begin
              twc_next = '0;
              track_next = (track_reg == TRK_W'(NUM_TRACKS - 1)) ? '0 : track_reg + 1'b1;
            end else begin
              twc_next = twc_reg + 1'b1;
            end
            if (word_cnt_reg == REC_AW'(RECW - 1)) begin
              word_cnt_next = '0;
              rec_done_next = 1'b1;
            end else begin
              word_cnt_next = word_cnt_reg + 1'b1;
            end
          end
          if (rec_done_reg) begin
            if (xfer_start) begin
              won_next[cur_grp] = 1'b1;
              if (cur_grp == GRP_LF) begin
                lf_range_next = (rec_cnt_reg < FAC_W'(LF_RANGE_MAX));
              end
            end
            if (rec_cnt_reg == FAC_W'(NUM_FAC - 1)) begin
              scan_next = SC_IDLE;
              done_next = 1'b1;
            end else begin
              rec_cnt_next = rec_cnt_reg + 1'b1;
            end
          end
        end
      endcase
    end
    rd_en_next = (scan_next == SC_RUN);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scan_reg <= SC_IDLE;
      for (int i = 0; i < RECW; i++) begin
        rec_mem_reg[i] <= '0;
      end
      word_cnt_reg <= '0;
      rec_cnt_reg <= '0;
      twc_reg <= '0;
      track_reg <= '0;
      won_reg <= '0;
      rec_done_reg <= 1'b0;
      rd_en_reg <= 1'b0;
      done_reg <= 1'b0;
      lf_range_reg <= 1'b0;
    end else begin
      scan_reg <= scan_next;
      rec_mem_reg <= rec_mem_next;
      word_cnt_reg <= word_cnt_next;
      rec_cnt_reg <= rec_cnt_next;
      twc_reg <= twc_next;
      track_reg <= track_next;
      won_reg <= won_next;
      rec_done_reg <= rec_done_next;
      rd_en_reg <= rd_en_next;
      done_reg <= done_next;
      lf_range_reg <= lf_range_next;
    end
  end

  // core transfer of the winning record, one word per grant
  logic [WORD_W-1:0] xbuf_reg [RECW];
  logic [WORD_W-1:0] xbuf_next [RECW];
  rap_grp_e xgrp_reg, xgrp_next;
  logic [REC_AW-1:0] widx_reg, widx_next;
  logic mem_wr_reg, mem_wr_next;
  logic [ADDR_W-1:0] mem_addr_reg, mem_addr_next;
  logic [WORD_W-1:0] mem_data_reg, mem_data_next;

  always_comb begin
    xf_next = xf_reg;
    xbuf_next = xbuf_reg;
    xgrp_next = xgrp_reg;
    widx_next = widx_reg;
    mem_wr_next = mem_wr_reg;
    mem_addr_next = mem_addr_reg;
    mem_data_next = mem_data_reg;
    unique case (xf_reg)
      XF_IDLE: begin
        if (xfer_start) begin
          xbuf_next = rec_mem_reg;
          xgrp_next = cur_grp;
          widx_next = '0;
          mem_wr_next = 1'b1;
          mem_addr_next = rap_core_addr(cur_grp, '0);
          mem_data_next = rec_mem_reg[0];
          xf_next = XF_SEND;
        end
      end
      XF_SEND: begin
        // request and word stand until the priority logic grants
        if (mem_gnt_i) begin
          if (widx_reg == REC_AW'(RECW - 1)) begin
            mem_wr_next = 1'b0;
            xf_next = XF_IDLE;
          end else begin
            widx_next = widx_reg + 1'b1;
            mem_addr_next = rap_core_addr(xgrp_reg, widx_reg + 1'b1);
            mem_data_next = xbuf_reg[widx_reg + 1'b1];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xf_reg <= XF_IDLE;
      for (int i = 0; i < RECW; i++) begin
        xbuf_reg[i] <= '0;
      end
      xgrp_reg <= GRP_LF;
      widx_reg <= '0;
      mem_wr_reg <= 1'b0;
      mem_addr_reg <= '0;
      mem_data_reg <= '0;
    end else begin
      xf_reg <= xf_next;
      xbuf_reg <= xbuf_next;
      xgrp_reg <= xgrp_next;
      widx_reg <= widx_next;
      mem_wr_reg <= mem_wr_next;
      mem_addr_reg <= mem_addr_next;
      mem_data_reg <= mem_data_next;
    end
  end

  // revolution watchdog and overrun flag; a new loss beats the index clear
  logic [CNT_W-1:0] wd_cnt_reg, wd_cnt_next;
  logic idx_lost_reg, idx_lost_next;
  logic overrun_reg, overrun_next;

  always_comb begin
    wd_cnt_next = wd_cnt_reg;
    idx_lost_next = idx_lost_reg;
    overrun_next = overrun_reg;
    if (idx_rise) begin
      wd_cnt_next = '0;
      idx_lost_next = 1'b0;
      overrun_next = 1'b0;
    end else if (wd_cnt_reg == WD_LIMIT) begin
      idx_lost_next = 1'b1;
    end else begin
      wd_cnt_next = wd_cnt_reg + 1'b1;
    end
    if (lost_evt) begin
      overrun_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wd_cnt_reg <= '0;
      idx_lost_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      wd_cnt_reg <= wd_cnt_next;
      idx_lost_reg <= idx_lost_next;
      overrun_reg <= overrun_next;
    end
  end

  // outputs straight from flops; the write gate flop never leaves zero
  logic wr_gate_reg;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_gate_reg <= 1'b0;
    end else begin
      wr_gate_reg <= 1'b0;
    end
  end

  assign drum_rd_en_o = rd_en_reg;
  assign drum_wr_en_o = wr_gate_reg;
  assign track_sel_o = track_reg;
  assign mem_wr_o = mem_wr_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_data_o = mem_data_reg;
  assign sel_valid_o = won_reg;
  assign lf_range_o = lf_range_reg;
  assign scan_done_o = done_reg;
  assign overrun_o = overrun_reg;
  assign idx_lost_o = idx_lost_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_start;
    xfer_start;
  endsequence
  sequence s_first_word;
    mem_wr_o && (mem_addr_o == rap_core_addr(xgrp_reg, '0)) && (mem_data_o == xbuf_reg[0]);
  endsequence

  a_drum_read_only: assert property (!drum_wr_en_o && track_sel_o < TRK_W'(NUM_TRACKS))
    else $error("facility track written or track out of range");
  a_one_per_group: assert property (xfer_start |-> !won_reg[cur_grp] ##1 won_reg[$past(cur_grp)])
    else $error("second winner in one group");
  a_pass_before_copy: assert property (xfer_start |-> f_ok && x_ok && y_ok)
    else $error("transfer without all tests passed");
  a_no_pass_no_copy: assert property (rec_done_reg && !all_pass |=> !mem_wr_o || $stable(mem_addr_o))
    else $error("transfer started by failing record");
  a_edge_inclusive: assert property (rec_mem_reg[W_FLO] <= rec_mem_reg[W_FHI] && tune == rec_mem_reg[W_FLO] |-> f_ok)
    else $error("equal limit rejected");
  a_copy_start_addr: assert property (s_start |=> s_first_word)
    else $error("core write not started");
  a_copy_hold: assert property (mem_wr_o && !mem_gnt_i |=> mem_wr_o && $stable(mem_addr_o) && $stable(mem_data_o))
    else $error("core write dropped before grant");
  a_scan_bound: assert property (rec_cnt_reg < FAC_W'(NUM_FAC))
    else $error("record counter past last facility");
  a_index_restart: assert property (idx_rise |=> rec_cnt_reg == '0 && won_reg == '0 && drum_rd_en_o)
    else $error("index did not restart the scan");
  a_marker_tune: assert property (cur_grp inside {GRP_OUTER, GRP_MIDDLE, GRP_FAN} |-> tune == MKR_TUNE)
    else $error("marker tested against wrong value");

endmodule : rap_preselector

// ---- test/rap_drum_model.sv ----
// drum and core memory partner of the preselector: record tracks and a granting core store
// assumes the core clock is shared with the design; the bench loads records and calls rev()
`timescale 1ns/1ns
module rap_drum_model (
  input wire logic clk_i,                                // core clock
  input wire logic slow_i,                               // grant one cycle in four
  input wire logic mem_wr_i,                             // core write request
  input wire logic [rap_pkg::ADDR_W-1:0] mem_addr_i,     // core write address
  input wire logic [rap_pkg::WORD_W-1:0] mem_data_i,     // core write data
  output logic drum_clk_o,                               // drum word clock
  output logic drum_idx_o,                               // revolution index
  output logic [rap_pkg::WORD_W-1:0] drum_data_o,        // facility word
  output logic mem_gnt_o                                 // core write accepted
);
  import rap_pkg::*;
  logic [WORD_W-1:0] rec [NUM_FAC][RECW];
  logic [WORD_W-1:0] mem [1 << ADDR_W];
  logic [1:0] phase_reg;
  int n_wr;

  // unused entries fail every frequency test, no tune reaches 0x3fff
  initial begin
    drum_clk_o = 1'b0;
    drum_idx_o = 1'b0;
    drum_data_o = '0;
    mem_gnt_o = 1'b0;
    phase_reg = 2'h0;
    n_wr = 0;
    for (int n = 0; n < NUM_FAC; n++) begin
      for (int k = 0; k < RECW; k++) begin
        rec[n][k] = 14'h3fff;
      end
    end
  end

  // stalling grant checks that the request stands until taken
  always @(posedge clk_i) begin
    phase_reg <= phase_reg + 2'h1;
    mem_gnt_o <= !slow_i || (phase_reg == 2'h2);
    if (mem_wr_i && mem_gnt_o) begin
      mem[mem_addr_i] <= mem_data_i;
      n_wr <= n_wr + 1;
    end
  end

  // marker pattern so a missing transfer is visible
  task automatic clear_mem();
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = 14'h2aaa;
    end
    n_wr = 0;
  endtask : clear_mem

  // one revolution: index, then every record word by word, read only
  task automatic rev();
    logic [WORD_W-1:0] w;
    @(posedge clk_i) drum_idx_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    drum_idx_o <= 1'b0;
    for (int n = 0; n < NUM_FAC; n++) begin
      for (int k = 0; k < RECW; k++) begin
        w = rec[n][k];
        drum_data_o <= w;
        repeat (3) @(posedge clk_i);
        drum_clk_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        drum_clk_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        drum_data_o <= ~w;  // hold over, old value must not linger
        repeat (2) @(posedge clk_i);
      end
    end
  endtask : rev
endmodule : rap_drum_model

// ---- test/testbench.sv ----
// self-checking bench of the preselector: whole revolutions against a drum and core model
// assumes a shortened revolution count so the missing-index alarm stays quiet between revolutions
`timescale 1ns/1ns
module testbench;
  import rap_pkg::*;
  localparam int REV_SIM = 26000;
  typedef struct packed {int n; logic [5:0][WORD_W-1:0] w;} rap_rec_s;
  typedef struct packed {
    logic [WORD_W-1:0] lf; logic [WORD_W-1:0] vhf; logic slow;
    logic [NUM_GRP-1:0] sel; logic rng; logic [NUM_GRP-1:0][8:0] win;
  } rap_row_s;
  // words: south, north, east, west, upper freq, lower freq
  localparam rap_rec_s RECS [7] = '{
    '{0, {14'h0200, 14'h0200, 14'h0100, 14'h0100, 14'h0500, 14'h0500}},
    '{126, {14'h0000, 14'h3fff, 14'h3fff, 14'h0000, 14'h06ff, 14'h0501}},
    '{127, {14'h0000, 14'h3fff, 14'h3fff, 14'h0000, 14'h09ff, 14'h09fe}},
    '{253, {14'h0000, 14'h3fff, 14'h3fff, 14'h0000, 14'h0a01, 14'h09ff}},
    '{254, {14'h0200, 14'h0300, 14'h0100, 14'h00ff, 14'h3fff, 14'h0000}},
    '{286, {14'h0000, 14'h3fff, 14'h0200, 14'h0101, 14'h3fff, 14'h0000}},
    '{349, {14'h01ff, 14'h0200, 14'h0100, 14'h0000, 14'h3fff, 14'h0000}}};
  localparam rap_row_s ROWS [2] = '{
    '{14'h0500, 14'h0a00, 1'b0, 5'b10111, 1'b1, {9'd349, 9'd0, 9'd254, 9'd253, 9'd0}},
    '{14'h0501, 14'h0a02, 1'b1, 5'b10101, 1'b0, {9'd349, 9'd0, 9'd254, 9'd0, 9'd126}}};
  logic clk_i, rstn_i, slow, drum_clk_i, drum_idx_i, mem_gnt_i;
  logic [WORD_W-1:0] drum_data_i, lf_tune_i, vhf_tune_i, ac_x_i, ac_y_i, mem_data_o;
  logic drum_rd_en_o, drum_wr_en_o, mem_wr_o, lf_range_o, scan_done_o, overrun_o, idx_lost_o;
  logic [TRK_W-1:0] track_sel_o;
  logic [ADDR_W-1:0] mem_addr_o;
  logic [NUM_GRP-1:0] sel_valid_o;
  int n_mismatch, checks_done, n_done;

  rap_preselector #(.REV_CYCLES(REV_SIM)) i_rap_preselector (.clk_i(clk_i), .rstn_i(rstn_i),
    .drum_clk_i(drum_clk_i), .drum_idx_i(drum_idx_i), .drum_data_i(drum_data_i), .lf_tune_i(lf_tune_i),
    .vhf_tune_i(vhf_tune_i), .ac_x_i(ac_x_i), .ac_y_i(ac_y_i), .mem_gnt_i(mem_gnt_i),
    .drum_rd_en_o(drum_rd_en_o), .drum_wr_en_o(drum_wr_en_o), .track_sel_o(track_sel_o),
    .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .sel_valid_o(sel_valid_o),
    .lf_range_o(lf_range_o), .scan_done_o(scan_done_o), .overrun_o(overrun_o), .idx_lost_o(idx_lost_o));
  rap_drum_model i_model (.clk_i(clk_i), .slow_i(slow), .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o),
    .mem_data_i(mem_data_o), .drum_clk_o(drum_clk_i), .drum_idx_o(drum_idx_i), .drum_data_o(drum_data_i),
    .mem_gnt_o(mem_gnt_i));

  // 40 ns period
  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;
  // completion pulses per revolution
  always @(posedge clk_i) if (scan_done_o === 1'b1) n_done++;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // one full revolution, then the winners' core blocks are compared word by word
  task automatic run_row(input rap_row_s r);
    logic [ADDR_W-1:0] a;
    lf_tune_i <= r.lf;
    vhf_tune_i <= r.vhf;
    slow <= r.slow;
    i_model.clear_mem();
    n_done = 0;
    i_model.rev();
    repeat (60) @(posedge clk_i);
    #1;
    chk(sel_valid_o, r.sel);
    chk(lf_range_o, r.rng);
    chk(i_model.n_wr, 8 * $countones(r.sel));
    chk(n_done, 1);
    chk({drum_rd_en_o, drum_wr_en_o, overrun_o, idx_lost_o}, 0);
    for (int g = 0; g < NUM_GRP; g++) begin
      for (int k = 0; k < RECW; k++) begin
        a = CORE_BASE + ADDR_W'(g * 8 + k);
        if (r.sel[g]) chk(i_model.mem[a], i_model.rec[r.win[g]][k]);
        else chk(i_model.mem[a], 14'h2aaa);
      end
    end
  endtask : run_row

  initial begin
    n_mismatch = 0;
    checks_done = 0;
    n_done = 0;
    rstn_i = 1'b0;
    slow = 1'b0;
    lf_tune_i = '0;
    vhf_tune_i = '0;
    ac_x_i = 14'h0100;
    ac_y_i = 14'h0200;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      for (int k = 0; k < 6; k++) i_model.rec[RECS[i].n][k] = RECS[i].w[k];
      i_model.rec[RECS[i].n][6] = WORD_W'(RECS[i].n);
      i_model.rec[RECS[i].n][7] = ~WORD_W'(RECS[i].n);
    end
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 2; i++) run_row(ROWS[i]);
    // reset in mid-scan: outputs clear, later words without an index are ignored
    lf_tune_i <= 14'h0500;
    vhf_tune_i <= 14'h0a00;
    n_done = 0;
    fork
      i_model.rev();
      begin
        repeat (2000) @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk({mem_wr_o, drum_rd_en_o, sel_valid_o, lf_range_o, scan_done_o, overrun_o, idx_lost_o}, 0);
        chk({track_sel_o, mem_addr_o, mem_data_o}, 0);
        i_model.clear_mem();
        @(posedge clk_i);
        rstn_i <= 1'b1;
      end
    join
    repeat (60) @(posedge clk_i);
    #1;
    chk(i_model.n_wr, 0);
    chk({drum_rd_en_o, sel_valid_o, drum_wr_en_o}, 0);
    chk(n_done, 0);
    // no index since the reset release: alarm after REV_SIM*9/8 clocks, not before
    repeat (5700) @(posedge clk_i);
    #1;
    chk(idx_lost_o, 0);
    repeat (400) @(posedge clk_i);
    #1;
    chk(idx_lost_o, 1);
    finish_test();
  end

  // expected run is about 82000 cycles
  initial begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    finish_test();
  end
endmodule : testbench
